// file: core/gcs_pkg.sv
// Constants shared by the chop conversion sequencer
package gcs_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] GCS_OFS_CTRL   = 8'h00;
    localparam logic [7:0] GCS_OFS_RATE   = 8'h04;
    localparam logic [7:0] GCS_OFS_DELAY  = 8'h08;
    localparam logic [7:0] GCS_OFS_STATUS = 8'h0c;
    localparam logic [7:0] GCS_OFS_RESULT = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GCS_CTRL_CONT_BIT   = 0;
    localparam int GCS_CTRL_START_BIT  = 1;
    localparam int GCS_CTRL_STOP_BIT   = 2;
    localparam int GCS_RATE_IDX_LSB    = 0;
    localparam int GCS_RATE_IDX_W      = 4;
    localparam int GCS_RATE_LOWLAT_BIT = 4;
    localparam int GCS_RATE_CHOP_BIT   = 5;
    localparam int GCS_DELAY_W         = 8;
    localparam int GCS_STAT_BUSY_BIT   = 0;
    localparam int GCS_STAT_POL_BIT    = 1;
    localparam int GCS_STAT_NEW_BIT    = 2;
    localparam int GCS_STAT_PRIME_BIT  = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] GCS_RST_RATE_IDX = 4'h4;
    localparam logic       GCS_RST_LOWLAT   = 1'b1;
    localparam logic       GCS_RST_CHOP     = 1'b0;
    localparam logic [7:0] GCS_RST_DELAY    = 8'h0e;

    // ------------------------------------------------------------
    // Timing: modulator period in converter clocks, table of one
    // conversion per rate in modulator periods (2.5 SPS first)
    // ------------------------------------------------------------
    localparam int GCS_CLK_PERIOD_NS = 40;
    localparam int GCS_MOD_DIV       = 16;
    localparam int GCS_NUM_RATES     = 14;
    localparam int GCS_CNT_W         = 20;

    localparam logic [19:0] GCS_LL_MODS [GCS_NUM_RATES] = '{
        20'h19681, 20'h0ce81, 20'h06a81, 20'h03c41, 20'h03881,
        20'h01428, 20'h010e9, 20'h00a28, 20'h00528, 20'h002a8,
        20'h00168, 20'h00128, 20'h000a8, 20'h00068};
    localparam logic [19:0] GCS_S3_MODS [GCS_NUM_RATES] = '{
        20'h4b041, 20'h25841, 20'h12c41, 20'h0b441, 20'h09641,
        20'h03c41, 20'h03239, 20'h01e41, 20'h00f41, 20'h007c1,
        20'h00401, 20'h00328, 20'h001a8, 20'h000e8};

    // ------------------------------------------------------------
    // Sequencer states, Gray along idle -> settle -> convert
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GCS_ST_IDLE    = 2'b00,
        GCS_ST_SETTLE  = 2'b01,
        GCS_ST_CONVERT = 2'b11
    } gcs_state_t;

endpackage : gcs_pkg

// file: core/gcs_mod_timer.sv
// Modulator-period timer: counts a loaded number of modulator periods
`timescale 1ns/1ns
module gcs_mod_timer
    import gcs_pkg::*;
#(
    parameter int MOD_DIV = GCS_MOD_DIV,
    parameter int CNT_W   = GCS_CNT_W
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_mods,
    output logic                  done
);
    localparam int PW = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
    localparam logic [PW-1:0] PRESC_TOP = PW'(MOD_DIV - 1);

    generate
        if (MOD_DIV < 1) begin : g_bad_div
            $error("gcs_mod_timer: MOD_DIV must be at least 1");
        end
    endgenerate

    logic [PW-1:0]    presc_ff;
    logic [CNT_W-1:0] rem_ff;
    logic             run_ff;
    logic             done_ff;

    wire tick    = run_ff && (presc_ff == PRESC_TOP);
    wire last    = tick && (rem_ff <= CNT_W'(1));

    // A fresh load always wins, so a restart never sees a stale done
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            presc_ff <= '0;
            rem_ff   <= '0;
            run_ff   <= 1'b0;
            done_ff  <= 1'b0;
        end else if (load) begin
            presc_ff <= '0;
            rem_ff   <= load_mods;
            run_ff   <= 1'b1;
            done_ff  <= 1'b0;
        end else begin
            presc_ff <= tick ? '0 : (run_ff ? presc_ff + PW'(1) : presc_ff);
            rem_ff   <= (tick && !last) ? rem_ff - CNT_W'(1) : rem_ff;
            run_ff   <= run_ff && !last;
            done_ff  <= last;
        end
    end

    assign done = done_ff;

endmodule : gcs_mod_timer

// file: core/gcs_chop_seq.sv
// Chop conversion sequencer with APB register file
// Function
// - With chop on, each corrected result pairs one normal-polarity and one reversed-polarity conversion; each sequence starts normal.
// - The corrected result is the average of the normal and the negated reversed conversion.
// - The chop enable is one bit of the data rate register at offset 04h.
// - With the low-latency filter the first chopped result takes about two conversion periods.
// - With the sinc3 filter the first chopped result takes about six conversion periods.
// - In continuous mode each later chopped result takes half the time of the first.
// - Alternating-polarity conversions are pipelined so in continuous mode every conversion after the first yields a new average.
// - Low-latency chopped timing follows the per-rate modulator-period table, later results half.
// - A sequence starts on a trigger pin rising edge, on a serial start command or on the start bit of the control register.
// - The settling delay is applied before each conversion, counted in modulator periods.
`timescale 1ns/1ns
module gcs_chop_seq
    import gcs_pkg::*;
#(
    parameter int          DATA_W  = 16,
    parameter int          MOD_DIV = GCS_MOD_DIV,
    parameter logic [19:0] LL_TABLE [GCS_NUM_RATES] = GCS_LL_MODS,
    parameter logic [19:0] S3_TABLE [GCS_NUM_RATES] = GCS_S3_MODS
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Start sources
    input  wire logic              start_pin,
    input  wire logic              start_cmd,
    // Modulator and filter side
    input  wire logic [DATA_W-1:0] conv_data,
    output logic                   input_swap,
    output logic                   conv_active,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_ready
);

    generate
        if (DATA_W < 2 || DATA_W > 32) begin : g_bad_w
            $error("gcs_chop_seq: DATA_W must lie in 2..32");
        end
    endgenerate

    // ------------------------------------------------------------
    // APB slave: one wait state, pready registered
    // ------------------------------------------------------------
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;

    logic                   cont_ff;
    logic [3:0]             rate_ff;
    logic                   lowlat_ff;
    logic                   chop_ff;
    logic [7:0]             delay_ff;
    logic                   new_ff;
    logic [DATA_W-1:0]      result_ff;

    wire access   = psel && penable;
    wire prep     = access && !pready_ff;
    wire commit   = access && pready_ff && !pslverr_ff;
    wire sel_ctrl = (paddr == GCS_OFS_CTRL);
    wire sel_rate = (paddr == GCS_OFS_RATE);
    wire sel_dly  = (paddr == GCS_OFS_DELAY);
    wire sel_stat = (paddr == GCS_OFS_STATUS);
    wire sel_res  = (paddr == GCS_OFS_RESULT);
    wire mapped   = sel_ctrl || sel_rate || sel_dly || sel_stat || sel_res;

    wire [3:0] wr_rate_idx = pwdata[GCS_RATE_IDX_LSB +: GCS_RATE_IDX_W];
    // Rates beyond the table have no timing, so such writes are refused
    wire bad_rate = pwrite && sel_rate &&
                    (wr_rate_idx > 4'(GCS_NUM_RATES - 1));
    wire bad_ro   = pwrite && (sel_stat || sel_res);

    wire wr_ctrl = commit && pwrite && sel_ctrl;
    wire wr_rate = commit && pwrite && sel_rate;
    wire wr_dly  = commit && pwrite && sel_dly;
    wire rd_res  = commit && !pwrite && sel_res;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    gcs_state_t             state_ff;
    gcs_state_t             nxt_state;
    logic                   pol_ff;
    logic                   primed_ff;
    logic                   pin_prev_ff;
    logic [DATA_W-1:0]      norm_ff;
    logic [DATA_W-1:0]      rev_ff;
    logic                   swap_ff;
    logic                   active_ff;
    logic [DATA_W-1:0]      dout_ff;
    logic                   drdy_ff;
    logic                   tmr_done;

    wire busy = (state_ff != GCS_ST_IDLE);

    wire [31:0] rd_data =
        sel_ctrl ? {31'h0, cont_ff} :
        sel_rate ? {26'h0, chop_ff, lowlat_ff, rate_ff} :
        sel_dly  ? {24'h0, delay_ff} :
        sel_stat ? {28'h0, primed_ff, new_ff, pol_ff, busy} :
        sel_res  ? 32'(result_ff) : 32'h0;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= prep;
            pslverr_ff <= prep && (!mapped || bad_rate || bad_ro);
            prdata_ff  <= (prep && !pwrite) ? rd_data : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cont_ff   <= 1'b0;
            rate_ff   <= GCS_RST_RATE_IDX;
            lowlat_ff <= GCS_RST_LOWLAT;
            chop_ff   <= GCS_RST_CHOP;
            delay_ff  <= GCS_RST_DELAY;
        end else begin
            if (wr_ctrl)
                cont_ff <= pwdata[GCS_CTRL_CONT_BIT];
            if (wr_rate) begin
                rate_ff   <= wr_rate_idx;
                lowlat_ff <= pwdata[GCS_RATE_LOWLAT_BIT];
                chop_ff   <= pwdata[GCS_RATE_CHOP_BIT];
            end
            if (wr_dly)
                delay_ff <= pwdata[GCS_DELAY_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Start, stop and restart decode
    // ------------------------------------------------------------
    wire pin_rise  = start_pin && !pin_prev_ff;
    wire apb_start = wr_ctrl && pwdata[GCS_CTRL_START_BIT];
    wire apb_stop  = wr_ctrl && pwdata[GCS_CTRL_STOP_BIT];
    wire cfg_diff  = (wr_rate_idx != rate_ff) ||
                     (pwdata[GCS_RATE_LOWLAT_BIT] != lowlat_ff) ||
                     (pwdata[GCS_RATE_CHOP_BIT] != chop_ff);
    wire cfg_kick  = wr_rate && busy && cfg_diff;
    wire restart   = pin_rise || start_cmd || apb_start || cfg_kick;

    // Timing follows the value being written when a change restarts
    wire [3:0] eff_rate   = wr_rate ? wr_rate_idx : rate_ff;
    wire       eff_lowlat = wr_rate ? pwdata[GCS_RATE_LOWLAT_BIT] : lowlat_ff;
    wire       eff_chop   = wr_rate ? pwdata[GCS_RATE_CHOP_BIT] : chop_ff;

    // Per-conversion time; the sinc3 entries already hold three-pass
    // settling, so a chopped pair spans about six periods
    wire [19:0] conv_mods = eff_lowlat ? LL_TABLE[eff_rate]
                                       : S3_TABLE[eff_rate];
    wire        has_delay = (delay_ff != 8'h0);

    // ------------------------------------------------------------
    // Capture and averaging
    // ------------------------------------------------------------
    wire conv_end = (state_ff == GCS_ST_CONVERT) && tmr_done;
    wire [DATA_W-1:0] pair_norm = pol_ff ? norm_ff : conv_data;
    wire [DATA_W-1:0] pair_rev  = pol_ff ? conv_data : rev_ff;
    // Reversed sample carries -input plus offset; subtracting cancels it
    wire signed [DATA_W:0] diff = $signed({pair_norm[DATA_W-1], pair_norm})
                                - $signed({pair_rev[DATA_W-1], pair_rev});
    wire [DATA_W-1:0] avg = diff[DATA_W:1];
    wire emit     = conv_end && (!chop_ff || primed_ff);
    wire go_again = conv_end && (cont_ff || (chop_ff && !primed_ff));

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic        tmr_load;
    logic [19:0] tmr_mods;

    always_comb begin
        nxt_state = state_ff;
        tmr_load  = 1'b0;
        tmr_mods  = conv_mods;
        if (apb_stop && !restart) begin
            nxt_state = GCS_ST_IDLE;
        end else if (restart || (go_again && !apb_stop)) begin
            tmr_load = 1'b1;
            if (has_delay) begin
                nxt_state = GCS_ST_SETTLE;
                tmr_mods  = 20'(delay_ff);
            end else begin
                nxt_state = GCS_ST_CONVERT;
            end
        end else begin
            case (state_ff)
                GCS_ST_SETTLE: begin
                    if (tmr_done) begin
                        nxt_state = GCS_ST_CONVERT;
                        tmr_load  = 1'b1;
                    end
                end
                GCS_ST_CONVERT: begin
                    if (tmr_done)
                        nxt_state = GCS_ST_IDLE;
                end
                default: nxt_state = GCS_ST_IDLE;
            endcase
        end
    end

    wire nxt_pol    = restart ? 1'b0 :
                      (conv_end && chop_ff) ? !pol_ff : pol_ff;
    wire nxt_primed = restart ? 1'b0 :
                      (conv_end && chop_ff) ? 1'b1 : primed_ff;
    // Set beats clear when a result lands during a result read
    wire nxt_new    = emit ? 1'b1 : (rd_res ? 1'b0 : new_ff);
    wire [DATA_W-1:0] nxt_result = chop_ff ? avg : conv_data;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff    <= GCS_ST_IDLE;
            pol_ff      <= 1'b0;
            primed_ff   <= 1'b0;
            pin_prev_ff <= 1'b0;
            new_ff      <= 1'b0;
            norm_ff     <= '0;
            rev_ff      <= '0;
            result_ff   <= '0;
        end else begin
            state_ff    <= nxt_state;
            pol_ff      <= nxt_pol;
            primed_ff   <= nxt_primed;
            pin_prev_ff <= start_pin;
            new_ff      <= nxt_new;
            if (conv_end && !pol_ff)
                norm_ff <= conv_data;
            if (conv_end && pol_ff)
                rev_ff <= conv_data;
            if (emit)
                result_ff <= nxt_result;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs to the modulator side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            swap_ff   <= 1'b0;
            active_ff <= 1'b0;
            dout_ff   <= '0;
            drdy_ff   <= 1'b0;
        end else begin
            swap_ff   <= nxt_pol && eff_chop;
            active_ff <= (nxt_state == GCS_ST_CONVERT);
            drdy_ff   <= emit;
            if (emit)
                dout_ff <= nxt_result;
        end
    end

    gcs_mod_timer #(
        .MOD_DIV (MOD_DIV),
        .CNT_W   (GCS_CNT_W)
    ) u_timer (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .load      (tmr_load),
        .load_mods (tmr_mods),
        .done      (tmr_done)
    );

    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign input_swap  = swap_ff;
    assign conv_active = active_ff;
    assign data_out    = dout_ff;
    assign data_ready  = drdy_ff;

endmodule : gcs_chop_seq

// file: verification/gcs_mod_model.sv
// Behavioural modulator and filter model feeding the sequencer
`timescale 1ns/1ns
module gcs_mod_model #(
    parameter int          DATA_W = 16,
    parameter logic [15:0] OFFSET = 16'h0123
) (
    input  wire logic              input_swap,
    input  wire logic [DATA_W-1:0] level,
    output logic [DATA_W-1:0]      conv_data
);
    // Offset rides on both polarities with one sign, so only the difference of the pair cancels it
    assign conv_data = input_swap ? (OFFSET - level) : (level + OFFSET);
endmodule : gcs_mod_model

// file: verification/gcs_chop_seq_asserts.sv
// Port checker for the chop conversion sequencer
`timescale 1ns/1ns
module gcs_chop_seq_asserts
    import gcs_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              start_pin,
    input wire logic              conv_active,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              data_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------
    // Length of one conversion phase
    // ------------------------------------------------
    logic [7:0] act_cnt_ff;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            act_cnt_ff <= 8'h00;
        else if (!conv_active)
            act_cnt_ff <= 8'h00;
        else if (act_cnt_ff != 8'hff)
            act_cnt_ff <= act_cnt_ff + 8'h01;
    end
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("APB answer not after one wait state");
    a_err_qual: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_ready_pulse: assert property (data_ready |=> !data_ready)
        else $error("data_ready longer than one cycle");
    a_out_hold: assert property (!data_ready |-> $stable(data_out))
        else $error("data_out changed without data_ready");
    a_pin_start: assert property ($rose(start_pin) |-> ##[1:16] conv_active)
        else $error("trigger rise did not start a conversion");
    a_active_bound: assert property (act_cnt_ff <= 8'h20)
        else $error("conversion phase too long");
endmodule : gcs_chop_seq_asserts

bind gcs_chop_seq gcs_chop_seq_asserts #(.DATA_W(DATA_W)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_pin(start_pin), .conv_active(conv_active),
    .data_out(data_out), .data_ready(data_ready));

// file: verification/tb_top.sv
// Self-checking bench for the chop conversion sequencer
`timescale 1ns/1ns
module tb_top
    import gcs_pkg::*;
;
    localparam logic [19:0] LL [GCS_NUM_RATES] = '{default: 20'h00004};
    localparam logic [19:0] S3 [GCS_NUM_RATES] = '{default: 20'h0000c};
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, input_swap, conv_active, data_ready;
    logic        start_pin = 1'b0, start_cmd = 1'b0;
    logic [15:0] level = 16'h0000, conv_data, data_out;
    int          failures = 0, n_tests = 0, t_ll = 0;

    gcs_chop_seq #(.DATA_W(16), .MOD_DIV(2), .LL_TABLE(LL), .S3_TABLE(S3))
    DUT (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_pin(start_pin), .start_cmd(start_cmd),
        .conv_data(conv_data), .input_swap(input_swap),
        .conv_active(conv_active), .data_out(data_out),
        .data_ready(data_ready));
    gcs_mod_model #(.DATA_W(16)) u_mod (.input_swap(input_swap),
        .level(level), .conv_data(conv_data));

    initial forever #20 sys_clk = ~sys_clk;
    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            failures++;
            complete_run();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Counts edges to the next result, conversions begun and swap seen
    task automatic wait_rdy(output int cyc, output int nc, output logic sw);
        logic pa;
        cyc = 0;
        nc = 0;
        sw = 1'b0;
        pa = conv_active;
        do begin
            @(posedge sys_clk);
            cyc++;
            if (conv_active === 1'b1 && pa !== 1'b1) nc++;
            pa = conv_active;
            if (input_swap === 1'b1) sw = 1'b1;
            if (cyc > 3000) begin
                failures++;
                complete_run();
            end
        end while (data_ready !== 1'b1);
    endtask : wait_rdy
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs();
        apb(0, GCS_OFS_RATE, 0, rd, er);
        chk("rate_rst", rd, 32'h00000014);
        apb(0, GCS_OFS_DELAY, 0, rd, er);
        chk("delay_rst", rd, 32'h0000000e);
        apb(0, 8'h20, 0, rd, er);
        chk("unmapped_err", er, 1);
        chk("unmapped_data", rd, 0);
        apb(1, GCS_OFS_STATUS, 32'h0000000f, rd, er);
        chk("ro_err", er, 1);
        apb(1, GCS_OFS_RATE, 32'h0000003e, rd, er);
        chk("bad_idx", er, 1);
        apb(0, GCS_OFS_RATE, 0, rd, er);
        chk("rate_kept", rd, 32'h00000014);
        apb(1, GCS_OFS_DELAY, 32'h00000001, rd, er);
        apb(1, GCS_OFS_RATE, 32'h00000034, rd, er);
        apb(0, GCS_OFS_RATE, 0, rd, er);
        chk("chop_on", rd, 32'h00000034);
        $display("Test regs done");
    endtask : t_regs
    // Chop off: one plain conversion, offset left in, status flag cycle
    task automatic t_nochop();
        int c, n;
        logic s;
        level <= 16'h1234;
        apb(1, GCS_OFS_RATE, 32'h00000014, rd, er);
        apb(1, GCS_OFS_CTRL, 32'h00000002, rd, er);
        wait_rdy(c, n, s);
        chk("plain_convs", n, 1);
        chk("plain_swap", s, 0);
        chk("plain_data", data_out, 16'h1234 + 16'h0123);
        apb(0, GCS_OFS_STATUS, 0, rd, er);
        chk("new_set", rd, 32'h00000004);
        apb(0, GCS_OFS_RESULT, 0, rd, er);
        chk("result_rd", rd, 32'h00001357);
        apb(0, GCS_OFS_STATUS, 0, rd, er);
        chk("new_clr", rd, 32'h00000000);
        apb(1, GCS_OFS_RATE, 32'h00000034, rd, er);
        $display("Test nochop done");
    endtask : t_nochop
    task automatic t_single();
        int c, n;
        logic s;
        level <= 16'h1234;
        apb(1, GCS_OFS_CTRL, 32'h00000002, rd, er);
        wait_rdy(c, n, s);
        t_ll = c;
        chk("pairs", n, 2);
        chk("swapped", s, 1);
        chk("avg", data_out, 16'h1234);
        repeat (40) @(posedge sys_clk);
        chk("idle", conv_active, 0);
        $display("Test single done");
    endtask : t_single
    task automatic t_cont();
        int c1, c2, n;
        logic s;
        level <= 16'hfed0;
        apb(1, GCS_OFS_CTRL, 32'h00000001, rd, er);
        start_pin <= 1'b1;
        wait_rdy(c1, n, s);
        chk("avg_neg", data_out, 16'hfed0);
        wait_rdy(c2, n, s);
        chk("one_conv", n, 1);
        chk("half", (c1 - 2 * c2) inside {[-4:4]}, 1);
        chk("conv_len", c2 inside {[12:16]}, 1);
        chk("avg_next", data_out, 16'hfed0);
        start_pin <= 1'b0;
        apb(1, GCS_OFS_CTRL, 32'h00000004, rd, er);
        repeat (40) @(posedge sys_clk);
        chk("stopped", conv_active, 0);
        $display("Test cont done");
    endtask : t_cont
    task automatic t_sinc3();
        int c, n;
        logic s;
        apb(1, GCS_OFS_RATE, 32'h00000024, rd, er);
        start_cmd <= 1'b1;
        @(posedge sys_clk);
        start_cmd <= 1'b0;
        wait_rdy(c, n, s);
        chk("s3_pairs", n, 2);
        chk("s3_len", (c - t_ll) inside {[28:36]}, 1);
        chk("s3_avg", data_out, 16'hfed0);
        $display("Test sinc3 done");
    endtask : t_sinc3
    task automatic t_restart();
        int c, n, k;
        logic s;
        apb(1, GCS_OFS_RATE, 32'h00000034, rd, er);
        apb(1, GCS_OFS_CTRL, 32'h00000003, rd, er);
        for (k = 0; k < 200 && input_swap !== 1'b1; k++) @(posedge sys_clk);
        chk("swap_seen", input_swap, 1);
        level <= 16'h0321;
        apb(1, GCS_OFS_RATE, 32'h00000024, rd, er);
        repeat (2) @(posedge sys_clk);
        chk("pol_reset", input_swap, 0);
        wait_rdy(c, n, s);
        chk("re_pairs", n, 2);
        chk("re_avg", data_out, 16'h0321);
        apb(1, GCS_OFS_CTRL, 32'h00000004, rd, er);
        $display("Test restart done");
    endtask : t_restart

    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_nochop();
        t_single();
        t_cont();
        t_sinc3();
        t_restart();
        complete_run();
    end
endmodule : tb_top
